// File: verilog/usc_top.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
`include "usc_map.svh"
// Summary of operation
// - transmit pin driven only while the transmit pin enable is set
// - clock pin as input clocks engines; as output carries baud generator
// - asynchronous mode: sixteen phases per bit from the 16x tick
// - shifter takes holding buffer, sets buffer empty; buffer write clears it
// - transmit active set while sending, cleared after final stop bit
// - asynchronous receive: low line, recheck at half bit, then one mid-bit sample per bit
// - finished character copied to holding buffer, full set; read clears
// - frame error activity flag set on framing error, cleared on high line
// - synchronous: transmit on rising edge, receive on falling edge
// - synchronous with clock output: internal generator clocks each engine whose external clock select is clear
// - length code: 01 seven bits, 00 eight bits, 10 nine bits
// - nine-bit: ninth bit from control bit, stored in read-only flag, no parity
// - one or two stop bits, last one optionally seven eighths long
// - parity only for seven and eight bits, when enabled, type from selects
// - ninth transmit bit doubles as low parity select
// - receiver needs one stop bit whatever the stop setting
// - transmit request while buffer empty and enable; write removes it
// - receive request while buffer full and enable; read removes it
// - receive and transmit vectors are separate two-byte locations
// - transmit and receive clock sources chosen independently
// - prescaler 1 to 16 in half steps, then 11-bit divider
// - prescaler code zero stops the serial clock
// - parity select 00 odd, 01 even, 10 mark, 11 space
// - both length bits set: transmitter looped into receiver, nine bits
// - attention mode drops characters until ninth bit set, then clears itself
module usc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin_out,
  output logic             serial_tx_pin_oe,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  output logic             tx_irq,
  output logic             rx_irq
);
  import usc_pkg::*;

  usc_state_t  st_reg;
  usc_state_t  st_next;
  usc_rxcs_t   rcap;
  logic        setup;
  logic        wr;
  logic        rd;
  logic        hit;
  logic        wr_txbuf;
  logic        rd_rxbuf;
  logic        rd_rxcs;
  logic        loop;
  logic        nine;
  logic        par_on;
  logic        sync;
  logic        rin;
  logic        ext_rise;
  logic        ext_fall;
  logic        tx_tick;
  logic        rx_tick;
  logic        tx_bend;
  logic        tx_load;
  logic        rx_samp;
  logic        rx_done;
  logic        rx_keep;
  logic [3:0]  nbits;
  logic [3:0]  tx_lim;
  logic [8:0]  rx_data;
  logic [31:0] rdv;

  usc_baud_if bif ();

  usc_baud_gen u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .bif     (bif)
  );

  function automatic logic par_bit(input logic p, input logic hi, input logic lo);
    // p is the xor of the data bits
    par_bit = hi ? ~lo : (lo ? p : ~p);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pwrite;
  assign rd       = psel & penable & ~pwrite;
  assign hit      = paddr inside {`USC_A_TXBUF, `USC_A_RXBUF, `USC_A_MAIN, `USC_A_RXCS,
                                  `USC_A_INTCLK, `USC_A_PSR, `USC_A_BAUD, `USC_A_CLKPIN};
  assign wr_txbuf = wr && paddr == `USC_A_TXBUF;
  assign rd_rxbuf = rd && paddr == `USC_A_RXBUF;
  assign rd_rxcs  = rd && paddr == `USC_A_RXCS;
  assign rcap     = usc_rxcs_t'(st_reg.prdata[7:0]);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = st_reg.prdata;

  ////////////////////////////////////////////////////////////////////////////////
  // frame format and clock selection
  assign loop    = st_reg.main.char_len_hi & st_reg.main.char_len_lo;
  assign nine    = st_reg.main.char_len_hi;
  assign par_on  = st_reg.main.parity_enable & ~nine;
  assign sync    = st_reg.ic.sync_sel;
  assign nbits   = nine ? `USC_MAX_BITS : (st_reg.main.char_len_lo ? `USC_BITS_7 : `USC_BITS_8);
  assign rin     = loop ? st_reg.tx_line : serial_rx_pin;
  assign ext_rise = serial_clock_pin_in & ~st_reg.ext_q;
  assign ext_fall = ~serial_clock_pin_in & st_reg.ext_q;
  // independent sources; synchronous edges per direction
  assign tx_tick = st_reg.ic.tx_ext_clk ? ext_rise : (sync ? bif.sclk_rise : bif.tick16);
  assign rx_tick = st_reg.ic.rx_ext_clk ? (sync ? ext_fall : ext_rise)
                                        : (sync ? bif.sclk_fall : bif.tick16);
  assign tx_lim  = (st_reg.tx_st == TX_STOP && !st_reg.tx_stop2 && st_reg.ic.stop_short)
                   ? `USC_SHORT_LAST : `USC_OVS_LAST;
  assign tx_bend = tx_tick && (sync || st_reg.tx_ph == tx_lim);
  assign tx_load = !st_reg.main.tx_buffer_empty && !wr_txbuf &&
                   ((st_reg.tx_st == TX_IDLE && (!sync || tx_tick)) ||
                    (st_reg.tx_st == TX_STOP && tx_bend && !st_reg.tx_stop2));
  assign rx_samp = rx_tick && (sync || st_reg.rx_ph == `USC_OVS_LAST) &&
                   (st_reg.rx_st inside {RX_DATA, RX_PARITY, RX_STOP});
  assign rx_done = rx_samp && st_reg.rx_st == RX_STOP;
  assign rx_data = st_reg.rx_shift >> (`USC_MAX_BITS - nbits);
  assign rx_keep = ~st_reg.rxcs.address_wait_mode | (nine & rx_data[8]);

  assign bif.presc_code = st_reg.prescaler_select_reg.presc_code;
  assign bif.divisor    = {st_reg.prescaler_select_reg.div_hi, st_reg.baud};

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next       = st_reg;
    st_next.ext_q = serial_clock_pin_in;
    case (paddr)
      `USC_A_TXBUF:  rdv = {24'h000000, st_reg.tx_hold};
      `USC_A_RXBUF:  rdv = {24'h000000, st_reg.rx_hold};
      `USC_A_MAIN:   rdv = {24'h000000, st_reg.main};
      `USC_A_RXCS:   rdv = {24'h000000, st_reg.rxcs};
      `USC_A_INTCLK: rdv = {24'h000000, st_reg.ic};
      `USC_A_PSR:    rdv = {24'h000000, st_reg.prescaler_select_reg};
      `USC_A_BAUD:   rdv = {24'h000000, st_reg.baud};
      `USC_A_CLKPIN: rdv = {31'h00000000, st_reg.clk_out_en};
      default:       rdv = 32'h00000000;
    endcase
    if (setup) begin
      st_next.prdata   = rdv;
      st_next.cap_full = st_reg.main.rx_buffer_full;
    end
    // software writes
    if (wr) begin
      case (paddr)
        `USC_A_TXBUF: begin
          st_next.tx_hold              = pwdata[7:0];
          st_next.main.tx_buffer_empty = 1'b0;
        end
        `USC_A_MAIN: begin
          st_next.main.parity_enable = pwdata[7];
          st_next.main.parity_sel_hi = pwdata[6];
          st_next.main.tx_ninth_bit  = pwdata[5];
          st_next.main.char_len_hi   = pwdata[4];
          st_next.main.char_len_lo   = pwdata[3];
        end
        `USC_A_RXCS: begin
          st_next.rxcs.spare             = pwdata[4];
          st_next.rxcs.address_wait_mode = pwdata[2];
        end
        `USC_A_INTCLK: st_next.ic = usc_intclk_t'(pwdata[7:0]);
        `USC_A_PSR:    st_next.prescaler_select_reg = usc_psr_t'(pwdata[7:0]);
        `USC_A_BAUD:   st_next.baud = pwdata[7:0];
        `USC_A_CLKPIN: st_next.clk_out_en = pwdata[0];
        default: begin
        end
      endcase
    end
    // read side effects clear only what the reader saw
    if (rd_rxbuf && st_reg.cap_full) begin
      st_next.main.rx_buffer_full = 1'b0;
    end
    if (rd_rxcs) begin
      st_next.rxcs.doe = st_reg.rxcs.doe & ~rcap.doe;
      st_next.rxcs.fe  = st_reg.rxcs.fe & ~rcap.fe;
      st_next.rxcs.pe  = st_reg.rxcs.pe & ~rcap.pe;
    end
    if (rin) begin
      st_next.rxcs.rx_frame_err_active = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmitter
    if (st_reg.tx_st != TX_IDLE) begin
      if (tx_tick) begin
        st_next.tx_ph = 4'(st_reg.tx_ph + 4'h1);
      end
      if (tx_bend) begin
        st_next.tx_ph = 4'h0;
        case (st_reg.tx_st)
          TX_START: begin
            st_next.tx_st = TX_DATA;
          end
          TX_DATA: begin
            st_next.tx_par   = st_reg.tx_par ^ st_reg.tx_shift[0];
            st_next.tx_shift = {1'b1, st_reg.tx_shift[8:1]};
            st_next.tx_bits  = 4'(st_reg.tx_bits + 4'h1);
            if (st_reg.tx_bits == 4'(nbits - 4'h1)) begin
              st_next.tx_st = par_on ? TX_PARITY : TX_STOP;
            end
          end
          TX_PARITY: begin
            st_next.tx_st = TX_STOP;
          end
          default: begin
            if (st_reg.tx_stop2) begin
              st_next.tx_stop2 = 1'b0;
            end else begin
              st_next.tx_st          = TX_IDLE;
              st_next.rxcs.tx_active = 1'b0;
            end
          end
        endcase
      end
    end
    if (st_next.tx_st == TX_STOP && st_reg.tx_st != TX_STOP) begin
      st_next.tx_stop2 = st_reg.ic.stop_two;
    end
    if (tx_load) begin
      st_next.tx_shift             = {st_reg.main.tx_ninth_bit, st_reg.tx_hold};
      st_next.main.tx_buffer_empty = 1'b1;
      st_next.rxcs.tx_active       = 1'b1;
      st_next.tx_st                = TX_START;
      st_next.tx_ph                = 4'h0;
      st_next.tx_bits              = 4'h0;
      st_next.tx_par               = 1'b0;
    end
    case (st_next.tx_st)
      TX_START:  st_next.tx_line = 1'b0;
      TX_DATA:   st_next.tx_line = st_next.tx_shift[0];
      TX_PARITY: st_next.tx_line = par_bit(st_next.tx_par, st_reg.main.parity_sel_hi,
                                           st_reg.main.tx_ninth_bit);
      default:   st_next.tx_line = 1'b1;
    endcase

    ////////////////////////////////////////////////////////////////////////////////
    // receiver
    case (st_reg.rx_st)
      RX_IDLE: begin
        if (rx_tick && !rin && !st_reg.rxcs.rx_frame_err_active) begin
          st_next.rx_st   = sync ? RX_DATA : RX_START;
          st_next.rx_ph   = 4'h0;
          st_next.rx_bits = 4'h0;
          st_next.rx_par  = 1'b0;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          st_next.rx_ph = 4'(st_reg.rx_ph + 4'h1);
          if (st_reg.rx_ph == `USC_HALF_BIT) begin
            st_next.rx_ph = 4'h0;
            st_next.rx_st = rin ? RX_IDLE : RX_DATA;
          end
        end
      end
      default: begin
        if (rx_tick) begin
          st_next.rx_ph = 4'(st_reg.rx_ph + 4'h1);
        end
        if (rx_samp) begin
          case (st_reg.rx_st)
            RX_DATA: begin
              st_next.rx_shift = {rin, st_reg.rx_shift[8:1]};
              st_next.rx_par   = st_reg.rx_par ^ rin;
              st_next.rx_bits  = 4'(st_reg.rx_bits + 4'h1);
              if (st_reg.rx_bits == 4'(nbits - 4'h1)) begin
                st_next.rx_st = par_on ? RX_PARITY : RX_STOP;
              end
            end
            RX_PARITY: begin
              if (rin != par_bit(st_reg.rx_par, st_reg.main.parity_sel_hi, st_reg.main.tx_ninth_bit)) begin
                st_next.rxcs.pe = 1'b1;
              end
              st_next.rx_st = RX_STOP;
            end
            default: begin
              // one stop bit checked regardless of transmit stop setting
              st_next.rx_st = RX_IDLE;
              if (!rin) begin
                st_next.rxcs.fe                  = 1'b1;
                st_next.rxcs.rx_frame_err_active = 1'b1;
              end
              if (rx_keep) begin
                if (st_reg.main.rx_buffer_full && !(rd_rxbuf && st_reg.cap_full)) begin
                  st_next.rxcs.doe = 1'b1;
                end else begin
                  st_next.rx_hold             = rx_data[7:0];
                  st_next.rxcs.rx_ninth_bit   = nine & rx_data[8];
                  st_next.main.rx_buffer_full = 1'b1;
                end
                if (nine & rx_data[8]) begin
                  st_next.rxcs.address_wait_mode = 1'b0;
                end
              end
            end
          endcase
        end
      end
    endcase
    st_next.main.err = st_next.rxcs.doe | st_next.rxcs.fe | st_next.rxcs.pe;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= USC_ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins and requests
  assign serial_tx_pin_out    = st_reg.tx_line;
  assign serial_tx_pin_oe     = st_reg.ic.tx_pin_enable;
  assign serial_clock_pin_out = bif.sclk_level;
  assign serial_clock_pin_oe  = st_reg.clk_out_en;
  // each request feeds its own vector slot
  assign tx_irq = st_reg.main.tx_buffer_empty & st_reg.ic.tx_irq_enable;
  assign rx_irq = st_reg.main.rx_buffer_full & st_reg.ic.rx_irq_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_tx_load;
    st_reg.tx_st == TX_IDLE && !st_reg.main.tx_buffer_empty && !wr_txbuf && (!sync || tx_tick);
  endsequence
  sequence s_rx_false;
    st_reg.rx_st == RX_START && rx_tick && st_reg.rx_ph == `USC_HALF_BIT && rin;
  endsequence
  sequence s_rx_store;
    rx_done && rx_keep && !st_reg.main.rx_buffer_full;
  endsequence

  tx_load_a: assert property (s_tx_load |=> st_reg.main.tx_buffer_empty && st_reg.tx_st == TX_START ##1
    !st_reg.tx_line) else $error("transmit load missed");
  tx_write_a: assert property (wr_txbuf |=> !st_reg.main.tx_buffer_empty && !tx_irq)
    else $error("buffer write did not clear empty");
  tx_busy_a: assert property (st_reg.tx_st != TX_IDLE |-> st_reg.rxcs.tx_active)
    else $error("transmit active low while sending");
  rx_false_a: assert property (s_rx_false |=> st_reg.rx_st == RX_IDLE)
    else $error("false start accepted");
  rx_store_a: assert property (s_rx_store |=> st_reg.main.rx_buffer_full &&
    rx_irq == st_reg.ic.rx_irq_enable) else $error("character not stored");
  rx_read_a: assert property (rd_rxbuf && st_reg.cap_full && !rx_done |=> !st_reg.main.rx_buffer_full
    && !rx_irq) else $error("read did not clear full");
  rx_ferr_a: assert property (rx_done && !rin |=> st_reg.rxcs.rx_frame_err_active && st_reg.rxcs.fe)
    else $error("framing error not flagged");
  rx_address_wait_mode_a: assert property (rx_done && !rx_keep && !wr |=> st_reg.rx_hold == $past(st_reg.rx_hold)
    && st_reg.rxcs.address_wait_mode) else $error("attention mode kept a data character");
endmodule

// File: inc/usc_map.svh
`ifndef USC_MAP_SVH
`define USC_MAP_SVH
// register byte addresses
`define USC_A_TXBUF    8'h00
`define USC_A_RXBUF    8'h04
`define USC_A_MAIN     8'h08
`define USC_A_RXCS     8'h0c
`define USC_A_INTCLK   8'h10
`define USC_A_PSR      8'h14
`define USC_A_BAUD     8'h18
`define USC_A_CLKPIN   8'h1c
// reset value of the main control/status register
`define USC_MAIN_RST   8'h01
// oversampling phases
`define USC_OVS_LAST   4'hf
`define USC_HALF_BIT   4'h7
`define USC_SHORT_LAST 4'hd
// character lengths
`define USC_MAX_BITS   4'h9
`define USC_BITS_8     4'h8
`define USC_BITS_7     4'h7
// prescaler works in half steps
`define USC_PRE_STEP   6'h02
// interrupt vector locations in program memory
`define USC_VEC_RX     8'hec
`define USC_VEC_TX     8'hee
`endif

// File: inc/usc_pkg.sv
`include "usc_map.svh"
package usc_pkg;
  typedef struct packed {
    logic parity_enable;
    logic parity_sel_hi;
    logic tx_ninth_bit;
    logic char_len_hi;
    logic char_len_lo;
    logic err;
    logic rx_buffer_full;
    logic tx_buffer_empty;
  } usc_main_t;
  typedef struct packed {
    logic doe;
    logic fe;
    logic pe;
    logic spare;
    logic rx_ninth_bit;
    logic address_wait_mode;
    logic tx_active;
    logic rx_frame_err_active;
  } usc_rxcs_t;
  typedef struct packed {
    logic stop_two;
    logic stop_short;
    logic tx_pin_enable;
    logic sync_sel;
    logic rx_ext_clk;
    logic tx_ext_clk;
    logic rx_irq_enable;
    logic tx_irq_enable;
  } usc_intclk_t;
  typedef struct packed {
    logic [4:0] presc_code;
    logic [2:0] div_hi;
  } usc_psr_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} usc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} usc_rx_st_t;
  typedef struct packed {
    usc_main_t   main;
    usc_rxcs_t   rxcs;
    usc_intclk_t ic;
    usc_psr_t    prescaler_select_reg;
    logic [7:0]  baud;
    logic        clk_out_en;
    logic [7:0]  tx_hold;
    logic [8:0]  tx_shift;
    logic        tx_line;
    usc_tx_st_t  tx_st;
    logic [3:0]  tx_ph;
    logic [3:0]  tx_bits;
    logic        tx_par;
    logic        tx_stop2;
    logic [8:0]  rx_shift;
    logic [7:0]  rx_hold;
    usc_rx_st_t  rx_st;
    logic [3:0]  rx_ph;
    logic [3:0]  rx_bits;
    logic        rx_par;
    logic        ext_q;
    logic        cap_full;
    logic [31:0] prdata;
  } usc_state_t;
  typedef struct packed {
    logic [5:0]  acc;
    logic [10:0] cnt;
    logic        tick;
    logic        sclk;
  } usc_bg_t;
  localparam usc_state_t USC_ST_RST = '{main: usc_main_t'(`USC_MAIN_RST), tx_line: 1'b1,
                                        tx_st: TX_IDLE, rx_st: RX_IDLE, default: '0};
endpackage

// File: inc/usc_baud_if.sv
`timescale 1ns/100ps
interface usc_baud_if;
  logic [4:0]  presc_code;
  logic [10:0] divisor;
  logic        tick16;
  logic        sclk_level;
  logic        sclk_rise;
  logic        sclk_fall;
  modport gen (input presc_code, input divisor, output tick16, output sclk_level, output sclk_rise,
               output sclk_fall);
  modport user (output presc_code, output divisor, input tick16, input sclk_level, input sclk_rise,
                input sclk_fall);
endinterface

// File: verilog/usc_baud_gen.sv
`timescale 1ns/100ps
`include "usc_map.svh"
module usc_baud_gen (
  input wire logic pclk,
  input wire logic presetn,
  usc_baud_if.gen  bif
);
  import usc_pkg::*;
  usc_bg_t    bg_reg;
  usc_bg_t    bg_next;
  logic [5:0] sum;
  logic [5:0] lim;
  logic       ptick;

  always_comb begin
    bg_next      = bg_reg;
    bg_next.tick = 1'b0;
    sum          = bg_reg.acc + `USC_PRE_STEP;
    lim          = {1'b0, bif.presc_code} + 6'h01;
    ptick        = 1'b0;
    if (bif.presc_code == 5'h00) begin
      // no clock: dividers cleared to zero, power down
      bg_next.acc = '0;
      bg_next.cnt = '0;
    end else begin
      // factor (code+1)/2 in half steps
      if (sum >= lim) begin
        ptick       = 1'b1;
        bg_next.acc = 6'(sum - lim);
      end else begin
        bg_next.acc = sum;
      end
      if (ptick) begin
        if (bg_reg.cnt == bif.divisor) begin
          bg_next.cnt  = '0;
          bg_next.tick = 1'b1;
          bg_next.sclk = ~bg_reg.sclk;
        end else begin
          bg_next.cnt = 11'(bg_reg.cnt + 11'h001);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_reg <= '0;
    end else begin
      bg_reg <= bg_next;
    end
  end

  assign bif.tick16     = bg_reg.tick;
  assign bif.sclk_level = bg_reg.sclk;
  assign bif.sclk_rise  = bg_reg.tick & bg_reg.sclk;
  assign bif.sclk_fall  = bg_reg.tick & ~bg_reg.sclk;

  bg_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    bif.presc_code == 5'h00 ##1 bif.presc_code == 5'h00 |-> !bif.tick16)
    else $error("tick while prescaler stopped");
  bg_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    ptick && bg_reg.cnt == bif.divisor && bif.presc_code != 5'h00 |=> bif.tick16 && bg_reg.cnt == 11'h000)
    else $error("divider did not wrap");
endmodule

// File: verification/usc_remote.sv
`timescale 1ns/100ps
module usc_remote (
  input  wire logic pclk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // start bit, then b[0] first; sixteen clocks per bit; line back to idle high after the frame
  task automatic send(input logic [10:0] b, input int n);
    line_out <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (16) @(posedge pclk);
      line_out <= (i == n) ? 1'b1 : b[i];
    end
    repeat (16) @(posedge pclk);
  endtask

  // waits for a start edge, then samples each bit at its middle
  task automatic recv(output logic [10:0] b, input int n);
    b = '0;
    @(negedge pclk);
    while (line_in !== 1'b0) @(negedge pclk);
    repeat (8) @(negedge pclk);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(negedge pclk);
      b[i] = line_in;
    end
  endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "usc_map.svh"
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ck_in = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, rx_line, tx_out, tx_oe, ck_out, ck_oe, tx_irq, rx_irq, last_err;
  // transmit pin has a pull-up while the device is not driving it
  wire         tx_line = tx_oe ? tx_out : 1'b1;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  initial forever #5 pclk = ~pclk;

  usc_top u_usc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(rx_line), .serial_tx_pin_out(tx_out), .serial_tx_pin_oe(tx_oe),
    .serial_clock_pin_in(ck_in), .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  usc_remote u_usc_remote (.pclk(pclk), .line_in(tx_line), .line_out(rx_line));

////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & mask, exp);
  endtask

  task automatic tx_one(input logic [7:0] m, input logic [7:0] d, input int n, input logic [10:0] e);
    logic [10:0] g;
    wr(`USC_A_MAIN, m);
    fork
      u_usc_remote.recv(g, n);
      wr(`USC_A_TXBUF, d);
    join
    chk(g, e);
    repeat (24) @(posedge pclk);
  endtask

////////////////////////////////////////////////////////////////
  task automatic s_reset();
    rd_chk(`USC_A_MAIN, 32'hffffffff, 32'h1);
    rd_chk(`USC_A_RXCS, 32'hffffffff, 32'h0);
    rd_chk(`USC_A_PSR, 32'hffffffff, 32'h0);
    rd_chk(8'h20, 32'hffffffff, 32'h0);
    chk(last_err, 1'b1);
    chk({tx_oe, tx_irq, rx_irq}, 3'b000);
  endtask

  task automatic s_clk();
    logic v;
    wr(`USC_A_CLKPIN, 8'h01);
    v = ck_out;
    repeat (3) @(posedge pclk);
    chk({ck_oe, ck_out}, {1'b1, v});
    wr(`USC_A_BAUD, 8'h00);
    wr(`USC_A_PSR, 8'h08);
    v = ck_out;
    @(posedge pclk);
    chk(ck_out, !v);
  endtask

  task automatic s_dbl();
    logic [10:0] g1, g2;
    logic [31:0] r;
    fork
      begin
        u_usc_remote.recv(g1, 9);
        u_usc_remote.recv(g2, 9);
      end
      begin
        wr(`USC_A_TXBUF, 8'h11);
        do apb(1'b0, `USC_A_MAIN, 32'h0, r); while (r[0] !== 1'b1);
        wr(`USC_A_TXBUF, 8'hc2);
        chk(tx_irq, 1'b0);
        rd_chk(`USC_A_MAIN, 32'h1, 32'h0);
        rd_chk(`USC_A_RXCS, 32'h2, 32'h2);
      end
    join
    chk({g2, g1}, {11'h1c2, 11'h111});
    repeat (16) @(posedge pclk);
    rd_chk(`USC_A_RXCS, 32'h2, 32'h0);
    chk(tx_irq, 1'b1);
  endtask

  task automatic s_rx();
    wr(`USC_A_INTCLK, 8'h23);
    u_usc_remote.send({3'b001, 8'h3c}, 9);
    chk(rx_irq, 1'b1);
    rd_chk(`USC_A_MAIN, 32'h2, 32'h2);
    rd_chk(`USC_A_RXBUF, 32'hff, 32'h3c);
    chk(rx_irq, 1'b0);
  endtask

  // line held low past the stop bit: framing error while the line stays low
  task automatic s_brk();
    logic [31:0] r;
    fork
      u_usc_remote.send(11'h000, 11);
      begin
        repeat (170) @(posedge pclk);
        rd_chk(`USC_A_RXCS, 32'h41, 32'h41);
      end
    join
    rd_chk(`USC_A_RXCS, 32'h1, 32'h0);
    apb(1'b0, `USC_A_RXBUF, 32'h0, r);
  endtask

  // odd parity selected, byte with odd weight sent with parity bit one
  task automatic s_par();
    wr(`USC_A_MAIN, 8'h80);
    u_usc_remote.send(11'h35b, 10);
    rd_chk(`USC_A_RXCS, 32'h20, 32'h20);
    rd_chk(`USC_A_RXBUF, 32'hff, 32'h5b);
  endtask

  // internal loop in attention mode: data character dropped, address character kept
  task automatic s_loop(input logic [7:0] ic);
    wr(`USC_A_INTCLK, ic);
    wr(`USC_A_RXCS, 8'h04);
    wr(`USC_A_MAIN, 8'h18);
    wr(`USC_A_TXBUF, 8'h55);
    repeat (200) @(posedge pclk);
    rd_chk(`USC_A_MAIN, 32'h2, 32'h0);
    wr(`USC_A_MAIN, 8'h38);
    wr(`USC_A_TXBUF, 8'ha6);
    repeat (200) @(posedge pclk);
    rd_chk(`USC_A_MAIN, 32'h2, 32'h2);
    rd_chk(`USC_A_RXCS, 32'h0c, 32'h08);
    rd_chk(`USC_A_RXBUF, 32'hff, 32'ha6);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_clk();
    wr(`USC_A_INTCLK, 8'h21);
    chk({tx_oe, tx_irq}, 2'b11);
    s_dbl();
    s_rx();
    s_brk();
    s_par();
    s_loop(8'h33);
    s_loop(8'h23);
    tx_one(8'h30, 8'h96, 10, {2'b11, 8'h96});
    tx_one(8'h08, 8'h2b, 8, {1'b1, 7'h2b});
    for (int k = 0; k < 4; k++) begin
      tx_one({1'b1, k[1:0], 5'h0}, 8'h5b, 10, {1'b1, k[1] ^ k[0], 8'h5b});
    end
    summarize();
  end
endmodule
